// >>> sds_pkg.sv
`default_nettype none
// ==========================================================
// Step/direction sequencer constants
package sds_pkg;
   // Frame layout of the serial link.
   localparam int SDS_FRAME_BITS = 40;
   localparam int SDS_WR_BIT     = 39;
   localparam int SDS_ADDR_LSB   = 32;
   localparam int SDS_ADDR_MSB   = 38;
   // Register addresses.
   localparam logic [6:0] SDS_ADDR_CONFIG  = 7'h00;
   localparam logic [6:0] SDS_ADDR_DIRECT  = 7'h2d;
   localparam logic [6:0] SDS_ADDR_COUNT   = 7'h6a;
   localparam logic [6:0] SDS_ADDR_CURRENT = 7'h6b;
   // Configuration fields and reset values.
   localparam int SDS_CFG_MRES_LSB = 0;
   localparam int SDS_CFG_DEDGE    = 4;
   localparam int SDS_CFG_DIRECT   = 5;
   localparam int SDS_COIL_B_LSB   = 16;
   localparam logic [3:0] SDS_MRES_RESET = 4'h0;
   localparam logic [3:0] SDS_MRES_FULL  = 4'h8;
   // Counter and waveform.
   localparam int SDS_CNT_W = 10;
   localparam int SDS_CUR_W = 9;
   localparam logic [9:0] SDS_QUARTER = 10'h100;
   localparam logic [9:0] SDS_STEP_UNIT = 10'h001;
   // Synchroniser reset: chip select and the pulled-up mode select idle high.
   localparam logic [9:0] SDS_SYNC_RESET = 10'h101;
   // Quarter sine, 33 points plus a guard copy of the peak.
   localparam logic [7:0] SDS_SINE_Q [0:33] = '{
      8'h00, 8'h0c, 8'h18, 8'h24, 8'h30, 8'h3c, 8'h48, 8'h53,
      8'h5f, 8'h6a, 8'h75, 8'h80, 8'h8a, 8'h94, 8'h9d, 8'ha6,
      8'haf, 8'hb8, 8'hc0, 8'hc7, 8'hce, 8'hd5, 8'hdb, 8'he0,
      8'he5, 8'he9, 8'hed, 8'hf0, 8'hf3, 8'hf5, 8'hf6, 8'hf7,
      8'hf8, 8'hf8};
endpackage : sds_pkg
`default_nettype wire

// >>> sds_sequencer.sv
// Contract
// - Step edges rising, or both with double-edge.
// - Direction sampled on each active step edge.
// - Resolution full step up to 256 microsteps.
// - Direction low increments, high decrements counter.
// - Table maps counter to sine and cosine.
// - Each frame is 40 bits each way.
// - Full duplex, one bit out per bit in.
// - Direct mode takes coil currents from writes.
// - Driver mode configuration comes over serial link.
// - Standalone mode configures from pins only.
// - Direct mode ignores step and direction.
// - Registers mostly write-only or read-only.
// - Select pin low standalone, high serial.
// - Chip select active low frames transaction.
`timescale 1ns/100ps
`default_nettype none
module sds_sequencer
   import sds_pkg::*;
(
   // System clock and reset.
   input  wire logic                        clk,
   input  wire logic                        reset_n,
   // Mode select and standalone configuration pins.
   input  wire logic                        spi_sel,
   input  wire logic [3:0]                  pin_mres,
   input  wire logic                        pin_dedge,
   // Step and direction inputs.
   input  wire logic                        step,
   input  wire logic                        dir,
   // Serial link.
   input  wire logic                        sck,
   input  wire logic                        cs_n,
   input  wire logic                        sdi,
   output logic                             sdo,
   output logic                             sdo_oe,
   // Coil currents and position.
   output logic signed [SDS_CUR_W-1:0]      coil_a,
   output logic signed [SDS_CUR_W-1:0]      coil_b,
   output logic [SDS_CNT_W-1:0]             ustep_count,
   output logic                             standalone
);

   // =======================================================
   // Link side, clocked by the serial clock
   localparam logic [5:0] LAST_BIT = 6'(SDS_FRAME_BITS - 1);
   localparam logic [5:0] FULL_CNT = 6'(SDS_FRAME_BITS);

   logic [5:0]                rx_cnt;
   logic [5:0]                tx_cnt;
   logic [SDS_FRAME_BITS-2:0] rx_shift;
   logic [SDS_FRAME_BITS-1:0] rx_hold;
   logic [SDS_FRAME_BITS-1:0] tx_hold;
   logic                      rx_done;

   wire       rx_take = (rx_cnt != FULL_CNT);
   wire       rx_last = (rx_cnt == LAST_BIT);
   wire [5:0] tx_idx  = LAST_BIT - tx_cnt;
   wire       tx_bit  = (tx_cnt != FULL_CNT) ? tx_hold[tx_idx] : 1'b0;

   // A deasserted select clears the frame state, so a cut frame is dropped.
   always_ff @(posedge sck or posedge cs_n)
   begin
      if (cs_n)
      begin
         rx_cnt  <= 6'h00;
         rx_done <= 1'b0;
      end
      else if (rx_take)
      begin
         rx_cnt <= rx_cnt + 6'h01;
         if (rx_last)
            rx_done <= 1'b1;
      end
   end

   // Data registers carry no reset; they are only read once rx_done is seen.
   always_ff @(posedge sck)
   begin
      if (rx_take)
         rx_shift <= {rx_shift[SDS_FRAME_BITS-3:0], sdi};
      if (rx_last)
         rx_hold <= {rx_shift, sdi};
   end

   // Bits leave on the falling edge so they are stable at the sampling edge.
   always_ff @(negedge sck or posedge cs_n)
   begin
      if (cs_n)
      begin
         tx_cnt <= 6'h00;
         sdo    <= 1'b0;
         sdo_oe <= 1'b0;
      end
      else
      begin
         sdo_oe <= 1'b1;
         sdo    <= tx_bit;
         if (tx_cnt != FULL_CNT)
            tx_cnt <= tx_cnt + 6'h01;
      end
   end

   // =======================================================
   // Pin synchronisers
   logic [9:0] sync1;
   logic [9:0] sync2;

   // Reset values follow the idle pin levels, so leaving reset shows no false mode or edge.
   wire [9:0] async_in = {rx_done, cs_n, pin_mres, pin_dedge, dir, step, spi_sel};

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         sync1 <= SDS_SYNC_RESET;
         sync2 <= SDS_SYNC_RESET;
      end
      else
      begin
         sync1 <= async_in;
         sync2 <= sync1;
      end
   end

   wire       spi_s   = sync2[0];
   wire       step_s  = sync2[1];
   wire       dir_s   = sync2[2];
   wire       dedge_p = sync2[3];
   wire [3:0] mres_p  = sync2[7:4];
   wire       idle_s  = sync2[8];
   wire       done_s  = sync2[9];

   // =======================================================
   // Configuration selection
   logic                        cfg_dedge;
   logic                        cfg_direct;
   logic [3:0]                  cfg_mres;
   logic signed [SDS_CUR_W-1:0] dir_a;
   logic signed [SDS_CUR_W-1:0] dir_b;
   logic [31:0]                 read_data;
   logic                        done_d;
   logic                        step_d;

   wire       pin_mode = ~spi_s;
   wire [3:0] mres_sel = pin_mode ? mres_p : cfg_mres;
   wire       dedge    = pin_mode ? dedge_p : cfg_dedge;
   wire       direct   = ~pin_mode & cfg_direct;
   wire [3:0] mres_eff = (mres_sel > SDS_MRES_FULL) ? SDS_MRES_FULL : mres_sel;

   // =======================================================
   // Step sequencer
   wire step_rise = step_s & ~step_d;
   wire step_edge = dedge ? (step_s ^ step_d) : step_rise;
   wire step_fire = step_edge & ~direct;

   wire [SDS_CNT_W-1:0] step_size = SDS_STEP_UNIT << mres_eff;
   wire [SDS_CNT_W-1:0] next_count = dir_s ? ustep_count - step_size
                                           : ustep_count + step_size;

   // Quarter-wave table with linear interpolation keeps the table small.
   function automatic logic signed [SDS_CUR_W-1:0] sds_sine(input logic [9:0] ph);
      logic [8:0]                  q;
      logic [5:0]                  idx;
      logic [7:0]                  lo;
      logic [7:0]                  hi;
      logic [10:0]                 prod;
      logic signed [SDS_CUR_W-1:0] m;
      q    = ph[8] ? (9'h100 - {1'b0, ph[7:0]}) : {1'b0, ph[7:0]};
      idx  = q[8:3];
      lo   = SDS_SINE_Q[idx];
      hi   = SDS_SINE_Q[idx + 6'h01];
      prod = ({3'h0, hi} - {3'h0, lo}) * {8'h00, q[2:0]};
      m    = {1'b0, lo + prod[10:3]};
      return ph[9] ? -m : m;
   endfunction : sds_sine

   wire signed [SDS_CUR_W-1:0] sine_a = sds_sine(ustep_count);
   wire signed [SDS_CUR_W-1:0] sine_b = sds_sine(ustep_count + SDS_QUARTER);

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         step_d      <= 1'b0;
         ustep_count <= '0;
         coil_a      <= '0;
         coil_b      <= '0;
         standalone  <= 1'b0;
      end
      else
      begin
         step_d     <= step_s;
         standalone <= pin_mode;
         if (step_fire)
            ustep_count <= next_count;
         coil_a <= direct ? dir_a : sine_a;
         coil_b <= direct ? dir_b : sine_b;
      end
   end

   // =======================================================
   // Register access
   wire       frame_new = done_s & ~done_d & ~pin_mode;
   wire       fr_write  = rx_hold[SDS_WR_BIT];
   wire [6:0] fr_addr   = rx_hold[SDS_ADDR_MSB:SDS_ADDR_LSB];
   wire [31:0] fr_data  = rx_hold[31:0];
   wire       wr_cfg    = frame_new & fr_write & (fr_addr == SDS_ADDR_CONFIG);
   wire       wr_dir    = frame_new & fr_write & (fr_addr == SDS_ADDR_DIRECT);

   // The direct register is write-only and reads as zero.
   wire [31:0] rd_cfg = {26'h0, cfg_direct, cfg_dedge, cfg_mres};
   wire [31:0] rd_mux = (fr_addr == SDS_ADDR_CONFIG)  ? rd_cfg :
                        (fr_addr == SDS_ADDR_COUNT)   ? {22'h0, ustep_count} :
                        (fr_addr == SDS_ADDR_CURRENT) ? {7'h0, coil_b, 7'h0, coil_a} :
                        32'h0;
   wire [7:0] status  = {6'h00, direct, pin_mode};

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         done_d     <= 1'b0;
         cfg_mres   <= SDS_MRES_RESET;
         cfg_dedge  <= 1'b0;
         cfg_direct <= 1'b0;
         dir_a      <= '0;
         dir_b      <= '0;
         read_data  <= 32'h0;
         tx_hold    <= '0;
      end
      else
      begin
         done_d <= done_s;
         if (wr_cfg)
         begin
            cfg_mres   <= fr_data[SDS_CFG_MRES_LSB +: 4];
            cfg_dedge  <= fr_data[SDS_CFG_DEDGE];
            cfg_direct <= fr_data[SDS_CFG_DIRECT];
         end
         if (wr_dir)
         begin
            dir_a <= fr_data[SDS_CUR_W-1:0];
            dir_b <= fr_data[SDS_COIL_B_LSB +: SDS_CUR_W];
         end
         if (frame_new)
            read_data <= rd_mux;
         // Frozen while a frame runs so the link side sees a static word.
         if (idle_s)
            tx_hold <= {status, read_data};
      end
   end

   // =======================================================
   // Assertions
   a_step_fwd_inc: assert property (@(posedge clk) disable iff (!reset_n)
      step_fire && !dir_s |=> ustep_count == $past(ustep_count) + $past(step_size))
      else $error("forward step did not add the step size");
   a_step_bwd_dec: assert property (@(posedge clk) disable iff (!reset_n)
      step_fire && dir_s |=> ustep_count == $past(ustep_count) - $past(step_size))
      else $error("backward step did not subtract the step size");
   a_fall_single_edge: assert property (@(posedge clk) disable iff (!reset_n)
      !dedge && !step_s && step_d |=> $stable(ustep_count))
      else $error("falling edge moved counter in single-edge mode");
   a_step_size_map: assert property (@(posedge clk) disable iff (!reset_n)
      mres_eff == SDS_MRES_FULL |-> step_size == SDS_QUARTER)
      else $error("full step is not a quarter period");
   // The reset term keeps the last reset cycle, whose coils are still zero, out of the window.
   a_table_origin: assert property (@(posedge clk) disable iff (!reset_n)
      (reset_n && !direct && ustep_count == 10'h000)[*2]
         |-> coil_a == 9'sh000 && coil_b == 9'sh0f8)
      else $error("coil currents wrong at counter zero");
   a_direct_coil: assert property (@(posedge clk) disable iff (!reset_n)
      direct |=> coil_a == $past(dir_a) && coil_b == $past(dir_b))
      else $error("direct mode coil current not from register");
   a_direct_no_step: assert property (@(posedge clk) disable iff (!reset_n)
      direct |=> $stable(ustep_count))
      else $error("counter moved in direct mode");
   a_pin_config: assert property (@(posedge clk) disable iff (!reset_n)
      !spi_s |-> mres_sel == mres_p && !direct ##1 standalone)
      else $error("standalone mode not using pin configuration");
   a_pin_no_write: assert property (@(posedge clk) disable iff (!reset_n)
      !spi_s |=> $stable(cfg_mres) && $stable(cfg_direct))
      else $error("serial write taken in standalone mode");
   // Sampled as the select rises, before it clears the frame counters.
   a_frame_done: assert property (@(posedge cs_n)
      rx_cnt == FULL_CNT |-> rx_done)
      else $error("frame not complete after 40 bits");
   a_duplex_bits: assert property (@(posedge sck) disable iff (cs_n)
      rx_cnt != FULL_CNT |-> tx_cnt == rx_cnt + 6'h01)
      else $error("bit out and bit in are not paired");

   c_step_fwd:  cover property (@(posedge clk) disable iff (!reset_n) step_fire && !dir_s);
   c_step_bwd:  cover property (@(posedge clk) disable iff (!reset_n) step_fire && dir_s);
   c_frame:     cover property (@(posedge clk) disable iff (!reset_n) frame_new);
   c_direct_on: cover property (@(posedge clk) disable iff (!reset_n) $rose(direct));
   c_cut_frame: cover property (@(posedge cs_n) rx_cnt != FULL_CNT && rx_cnt != 6'h00);

endmodule : sds_sequencer
`default_nettype wire

// >>> sds_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Serial master model
// The serial clock runs only inside frames and idles high between them.
module sds_host_model
(
   // Serial link.
   output logic        sck,
   output logic        cs_n,
   output logic        sdi,
   input  wire logic   sdo,
   // Reply word and its strobe.
   output logic [39:0] rx,
   output logic        done
);
   initial
   begin
      sck = 1'b1;
      cs_n = 1'b1;
      sdi = 1'b0;
      rx = 40'h0;
      done = 1'b0;
   end

   task automatic frame(input logic [39:0] tx, input int nbits);
      cs_n = 1'b0;
      #20;
      for (int i = 39; i > 39 - nbits; i--)
      begin
         sck = 1'b0;
         sdi = tx[i];
         #32;
         sck = 1'b1;
         rx = {rx[38:0], sdo};
         #32;
      end
      #16;
      cs_n = 1'b1;
      // A released line must not keep looking like the last bit.
      sdi = ~sdi;
      done = 1'b1;
      #40;
      done = 1'b0;
   endtask : frame
endmodule : sds_host_model
`default_nettype wire

// >>> stepper_step_dir_sequencer_test.sv
`timescale 1ns/100ps
`default_nettype none
module stepper_step_dir_sequencer_test
   import sds_pkg::*;
();
   logic clk, reset_n, spi_sel, pin_dedge, step, dir, sdo, sdo_oe, standalone;
   logic sck, cs_n, sdi, done, coil_chk;
   logic [3:0]  pin_mres;
   logic signed [8:0] coil_a, coil_b, va, vb;
   logic [9:0]  ustep_count, exp_cnt, last_cnt, prev_cnt;
   logic [39:0] rx;
   logic [40:0] rep;
   logic [31:0] cfg;
   logic [9:0]  cnt_q[$];
   logic [40:0] rep_q[$];
   int          num_errors, n_checks, seed, pm;

   sds_sequencer u_dut (.clk(clk), .reset_n(reset_n), .spi_sel(spi_sel),
      .pin_mres(pin_mres), .pin_dedge(pin_dedge), .step(step), .dir(dir),
      .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
      .coil_a(coil_a), .coil_b(coil_b), .ustep_count(ustep_count),
      .standalone(standalone));
   sds_host_model u_host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
      .rx(rx), .done(done));

   always #2 clk = ~clk;

   // ==========================================
   // Helpers
   function automatic logic signed [8:0] sine_at(input logic [9:0] c);
      logic signed [8:0] v;
      v = $signed({1'b0, SDS_SINE_Q[c[8] ? 32 - c[7:3] : c[7:3]]});
      return c[9] ? -v : v;
   endfunction : sine_at

   task automatic compare(input logic [39:0] got, input logic [39:0] exp, input string msg);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : compare

   task automatic spi(input logic [39:0] tx, input int nbits, input logic chk,
                      input logic [39:0] exp);
      rep_q.push_back({chk, exp});
      u_host.frame(tx, nbits);
      repeat (4) @(posedge clk);
      compare(sdo_oe, 40'h0, "sdo enable released");
      compare(sdo, 40'h0, "sdo released");
   endtask : spi

   task automatic wr(input logic [6:0] a, input logic [31:0] d);
      spi({1'b1, a, d}, 40, 1'b0, 40'h0);
   endtask : wr

   // Read data comes back one frame late, so the address is sent twice.
   task automatic rd(input logic [6:0] a, input logic [39:0] exp);
      spi({1'b0, a, 32'h0}, 40, 1'b0, 40'h0);
      spi({1'b0, a, 32'h0}, 40, 1'b1, exp);
   endtask : rd

   // A size of zero means the counter must not move.
   task automatic pulse(input logic d, input logic both, input int sz);
      dir <= d;
      repeat (4) @(posedge clk);
      step <= 1'b1;
      exp_cnt = d ? exp_cnt - sz[9:0] : exp_cnt + sz[9:0];
      if (sz != 0) cnt_q.push_back(exp_cnt);
      repeat (8) @(posedge clk);
      step <= 1'b0;
      exp_cnt = (both && d) ? exp_cnt - sz[9:0] : (both ? exp_cnt + sz[9:0] : exp_cnt);
      if (both && sz != 0) cnt_q.push_back(exp_cnt);
      repeat (8) @(posedge clk);
   endtask : pulse

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results

   // ==========================================
   // Watchers
   always @(negedge clk)
   begin
      if (reset_n === 1'b1 && ustep_count !== last_cnt)
      begin
         last_cnt = ustep_count;
         compare(ustep_count, cnt_q.size() ? cnt_q.pop_front() : 10'hx, "count");
      end
      if (coil_chk && ustep_count === prev_cnt && ustep_count[2:0] === 3'h0)
      begin
         compare(coil_a, sine_at(ustep_count), "coil a");
         compare(coil_b, sine_at(ustep_count + 10'h100), "coil b");
      end
      prev_cnt = ustep_count;
   end

   always @(posedge sck)
   begin
      if (cs_n === 1'b0) compare(sdo_oe, 40'h1, "sdo enable");
   end

   always @(posedge done)
   begin
      rep = rep_q.pop_front();
      if (rep[40]) compare(rx, rep[39:0], "reply");
   end

   initial
   begin
      #300000;
      $display("timeout at %0t", $time);
      num_errors++;
      results();
   end

   // ==========================================
   // Tests
   initial
   begin
      clk = 0; reset_n = 0; spi_sel = 1; pin_mres = 0; pin_dedge = 0; step = 0; dir = 0;
      seed = 32'h9bfd; exp_cnt = 0; last_cnt = 0; prev_cnt = 0; coil_chk = 0;
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge clk);
      compare(standalone, 0, "serial mode");
      compare(ustep_count, 0, "reset count");
      coil_chk = 1;
      for (int m = 0; m <= 8; m++)
      begin
         cfg = m;
         wr(SDS_ADDR_CONFIG, cfg);
         repeat (3) pulse($random(seed), 0, 1 << m);
      end
      $display("test resolutions done");
      cfg = 32'h13;
      wr(SDS_ADDR_CONFIG, cfg);
      repeat (4) pulse($random(seed), 1, 8);
      rd(SDS_ADDR_CONFIG, {8'h00, cfg});
      rd(SDS_ADDR_COUNT, {8'h00, 22'h0, exp_cnt});
      rd(7'h11, 40'h0);
      rd(SDS_ADDR_DIRECT, 40'h0);
      spi({1'b1, SDS_ADDR_CONFIG, 32'h0}, 20, 1'b0, 40'h0);
      rd(SDS_ADDR_CONFIG, {8'h00, cfg});
      $display("test double edge and readback done");
      coil_chk = 0;
      wr(SDS_ADDR_CONFIG, cfg | 32'h20);
      va = 9'($random(seed) % 249);
      vb = 9'($random(seed) % 249);
      wr(SDS_ADDR_DIRECT, {7'h0, vb, 7'h0, va});
      repeat (8) @(posedge clk);
      compare(coil_a, va, "direct a");
      compare(coil_b, vb, "direct b");
      rd(SDS_ADDR_CURRENT, {8'h02, 7'h0, vb, 7'h0, va});
      repeat (2) pulse($random(seed), 1, 0);
      rd(SDS_ADDR_CONFIG, {8'h02, cfg | 32'h20});
      wr(SDS_ADDR_CONFIG, cfg);
      repeat (4) @(posedge clk);
      coil_chk = 1;
      $display("test direct mode done");
      pm = $unsigned($random(seed)) % 9;
      spi_sel <= 1'b0;
      pin_mres <= pm[3:0];
      repeat (8) @(posedge clk);
      compare(standalone, 1, "standalone");
      wr(SDS_ADDR_CONFIG, (pm == 8) ? 32'h00 : 32'h08);
      repeat (3) pulse($random(seed), 0, 1 << pm);
      pin_dedge <= 1'b1;
      repeat (2) pulse($random(seed), 1, 1 << pm);
      $display("test standalone done");
      results();
   end
endmodule : stepper_step_dir_sequencer_test
`default_nettype wire
